// ---- hdl/umsr_pkg.sv ----
// Package: shared constants and carrier types for the master SPI port
package umsr_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned BAUD_W = 16;

  // Clock rate and period
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned CLK_PERIOD_NS = 8;

  // RS-485 control field encodings
  localparam logic [1:0] RS485_OFF = 2'h0;
  localparam logic [1:0] RS485_EXT = 2'h1;
  localparam logic [1:0] RS485_INT = 2'h2;

  // Reset values and bit count/index constants
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [BAUD_W-1:0] BAUD_RST = 16'h0000;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] BIT_ONE = 4'h1;
  localparam logic [BAUD_W-1:0] BAUD_ONE = 16'h0001;
  localparam logic [2:0] MSB_IDX = 3'h7;

  // Error flags, unused in master SPI mode
  localparam logic [2:0] ERR_NONE = 3'h0;

  // Shift engine states
  typedef enum logic [1:0] {
    UMSR_IDLE,
    UMSR_GUARD,
    UMSR_LEAD,
    UMSR_TRAIL
  } umsr_state_e;

  // Static configuration group
  typedef struct packed {
    logic tx_en;
    logic rx_en;
    logic cpol;
    logic cpha;
    logic lsb_first;
    logic [1:0] rs485;
    logic [BAUD_W-1:0] baud_div;
  } umsr_cfg_s;

  // Received word with its status flags
  typedef struct packed {
    logic [2:0] err;
    logic [DATA_W-1:0] data;
  } umsr_rx_s;

endpackage

// ---- hdl/umsr_buf2.sv ----
// Two-entry valid/ready buffer holding data words
`timescale 1ns/1ps
module umsr_buf2 #(
  parameter int unsigned W = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  logic [W-1:0] mem_ff [2];
  logic wr_ptr_ff;
  logic rd_ptr_ff;
  logic [1:0] cnt_ff;
  logic push;
  logic pop;

  // Honest flags: full at two, empty at zero
  assign in_ready_o = (cnt_ff != 2'h2);
  assign out_valid_o = (cnt_ff != 2'h0);
  assign out_data_o = mem_ff[rd_ptr_ff];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Storage written by index
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
    end else if (ce_i && push) begin
      mem_ff[wr_ptr_ff] <= in_data_i;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end else if (ce_i) begin
      if (flush_i) begin
        wr_ptr_ff <= 1'b0;
        rd_ptr_ff <= 1'b0;
        cnt_ff <= 2'h0;
      end else begin
        if (push) wr_ptr_ff <= ~wr_ptr_ff;
        if (pop) rd_ptr_ff <= ~rd_ptr_ff;
        if (push && !pop) cnt_ff <= cnt_ff + 2'h1;
        else if (pop && !push) cnt_ff <= cnt_ff - 2'h1;
      end
    end
  end
endmodule

// ---- hdl/umsr_baud.sv ----
// Baud tick generator: one pulse per half transfer-clock period
`timescale 1ns/1ps
module umsr_baud #(
  parameter int unsigned W = 16
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic run_i,
  input wire logic [W-1:0] div_i,
  output logic tick_o
);
  logic [W-1:0] cnt_ff;

  // Counts div_i+1 cycles per tick; restarts whenever the engine idles
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      if (!run_i || cnt_ff >= div_i) begin
        cnt_ff <= '0;
        tick_o <= run_i;
      end else begin
        cnt_ff <= cnt_ff + W'(1);
        tick_o <= 1'b0;
      end
    end
  end
endmodule

// ---- hdl/umsr_core.sv ----
// Master SPI serial port with RS-485 direction control
`timescale 1ns/1ps

module umsr_core #(
  parameter int unsigned DW = umsr_pkg::DATA_W
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire umsr_pkg::umsr_cfg_s cfg_i,
  input wire logic tx_wr_i,
  input wire logic [DW-1:0] tx_data_i,
  output logic tx_ready_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output umsr_pkg::umsr_rx_s rx_word_o,
  output logic tx_empty_o,
  output logic tx_done_o,
  output logic xfer_clk_o,
  output logic mosi_o,
  output logic mosi_oe_o,
  input wire logic miso_i,
  output logic tx_dir_o
);
  import umsr_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  umsr_state_e state_ff;
  logic [DW-1:0] tx_shift_ff;
  logic [DW-1:0] rx_shift_ff;
  logic [3:0] bit_cnt_ff;
  logic tick;
  logic run;
  logic txb_valid;
  logic txb_ready;
  logic [DW-1:0] txb_data;
  logic load;
  logic rx_push;
  logic [DW-1:0] rx_push_data;
  logic rxb_ready;
  logic rxb_valid;
  logic [DW-1:0] rxb_data;
  logic out_bit;
  logic last_bit;
  logic in_frame;
  logic rx_flush;
  logic rx_samp;
  logic rx_take;

  // ----------------------------------------------------------------
  // Transmit buffer
  // ----------------------------------------------------------------
  // Writes queue here while a frame shifts; no collision flag exists
  umsr_buf2 #(
    .W(DW)
  ) u_txbuf (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .flush_i(!cfg_i.tx_en),
    .in_valid_i(tx_wr_i && cfg_i.tx_en),
    .in_ready_o(txb_ready),
    .in_data_i(tx_data_i),
    .out_valid_o(txb_valid),
    .out_ready_i(load),
    .out_data_o(txb_data)
  );

  // ----------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------
  // Disabling the receiver flushes pending words at once
  assign rx_flush = !cfg_i.rx_en;
  // The output register mirrors the buffer head, so a word leaves the
  // buffer only when the consumer takes it from the output
  assign rx_take = rx_ready_i && rx_valid_o && cfg_i.rx_en;

  umsr_buf2 #(
    .W(DW)
  ) u_rxbuf (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .flush_i(rx_flush),
    .in_valid_i(rx_push),
    .in_ready_o(rxb_ready),
    .in_data_i(rx_push_data),
    .out_valid_o(rxb_valid),
    .out_ready_i(rx_take),
    .out_data_o(rxb_data)
  );

  // ----------------------------------------------------------------
  // Baud generator
  // ----------------------------------------------------------------
  // Only the divider sets the rate; there is no double-speed bit.
  // The divider is integer only, so the user picks a value whose rate
  // error stays inside the budget shared with the far receiver
  assign run = (state_ff != UMSR_IDLE);

  umsr_baud #(
    .W(BAUD_W)
  ) u_baud (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .run_i(run),
    .div_i(cfg_i.baud_div),
    .tick_o(tick)
  );

  // ----------------------------------------------------------------
  // Shift engine
  // ----------------------------------------------------------------
  // Outgoing bit selected by bit order select
  assign out_bit = cfg_i.lsb_first ? tx_shift_ff[0]
                                   : tx_shift_ff[MSB_IDX];
  assign last_bit = (bit_cnt_ff == LAST_BIT);
  // A new frame loads only when the engine is idle and a word waits;
  // a receive word that would overflow stalls the start instead
  assign load = (state_ff == UMSR_IDLE) && txb_valid && cfg_i.tx_en
                && (rxb_ready || !cfg_i.rx_en);
  assign in_frame = (state_ff == UMSR_LEAD) || (state_ff == UMSR_TRAIL);

  // Sample point follows the phase bit: phase 0 samples on the leading
  // edge, phase 1 on the trailing edge, half a period after the slave
  // has moved its bit; sampling stops at once if the transmitter drops
  assign rx_samp = tick && cfg_i.tx_en
                   && (cfg_i.cpha ? (state_ff == UMSR_TRAIL)
                                  : (state_ff == UMSR_LEAD));

  // Received word is pushed on the final sample edge
  assign rx_push = cfg_i.rx_en && rx_samp
                   && last_bit;
  assign rx_push_data = cfg_i.lsb_first ? {miso_i, rx_shift_ff[DW-1:1]}
                                        : {rx_shift_ff[DW-2:0], miso_i};

  // State sequencing: guard half period, then lead/trail per bit
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= UMSR_IDLE;
      bit_cnt_ff <= CNT_RST;
    end else if (ce_i) begin
      if (!cfg_i.tx_en) begin
        state_ff <= UMSR_IDLE;
        bit_cnt_ff <= CNT_RST;
      end else begin
        case (state_ff)
          UMSR_IDLE: begin
            bit_cnt_ff <= CNT_RST;
            if (load) state_ff <= UMSR_GUARD;
          end
          UMSR_GUARD: begin
            if (tick) state_ff <= UMSR_LEAD;
          end
          UMSR_LEAD: begin
            if (tick) state_ff <= UMSR_TRAIL;
          end
          UMSR_TRAIL: begin
            if (tick) begin
              if (last_bit) begin
                state_ff <= UMSR_IDLE;
              end else begin
                state_ff <= UMSR_LEAD;
                bit_cnt_ff <= bit_cnt_ff + BIT_ONE;
              end
            end
          end
          default: state_ff <= UMSR_IDLE;
        endcase
      end
    end
  end

  // Transmit shifter: with phase 0 the bit is set up before the
  // leading edge; with phase 1 it changes on the leading edge
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_shift_ff <= DATA_RST;
    end else if (ce_i) begin
      if (load) begin
        tx_shift_ff <= txb_data;
      end else if (tick && state_ff == UMSR_TRAIL && !last_bit) begin
        tx_shift_ff <= cfg_i.lsb_first ? {1'b0, tx_shift_ff[DW-1:1]}
                                       : {tx_shift_ff[DW-2:0], 1'b0};
      end
    end
  end

  // Receive shifter takes one bit at each sample point
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_shift_ff <= DATA_RST;
    end else if (ce_i) begin
      if (load) begin
        rx_shift_ff <= DATA_RST;
      end else if (rx_samp && cfg_i.rx_en) begin
        rx_shift_ff <= rx_push_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Clock toggles only inside the frame, resting at polarity level.
  // The phase bit moves data half a period later, as SPI CPHA does.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      xfer_clk_o <= 1'b0;
      mosi_o <= 1'b0;
    end else if (ce_i) begin
      // A dropped transmitter returns the pin to rest in the same cycle
      if (cfg_i.tx_en && state_ff == UMSR_LEAD && tick) begin
        xfer_clk_o <= ~cfg_i.cpol;
      end else if (!in_frame || !cfg_i.tx_en
                   || (state_ff == UMSR_TRAIL && tick)) begin
        xfer_clk_o <= cfg_i.cpol;
      end
      if (cfg_i.cpha) begin
        if (state_ff == UMSR_LEAD && tick) mosi_o <= out_bit;
      end else if (state_ff == UMSR_GUARD || state_ff == UMSR_LEAD) begin
        mosi_o <= out_bit;
      end
    end
  end

  // Direction output for both RS-485 modes; transmit pin enable follows the frame in internal mode only;
  // the guard half period gives the external driver time to turn on
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_dir_o <= 1'b0;
      mosi_oe_o <= 1'b0;
    end else if (ce_i) begin
      tx_dir_o <= (cfg_i.rs485 != RS485_OFF) && run
                  && cfg_i.tx_en;
      if (cfg_i.rs485 == RS485_INT) begin
        mosi_oe_o <= run && cfg_i.tx_en;
      end else begin
        mosi_oe_o <= cfg_i.tx_en;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  // Transmit flags mirror buffer state; a write in flight clears the
  // room flag for one cycle so a back-to-back write cannot overfill
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_ready_o <= 1'b0;
      tx_empty_o <= 1'b0;
      tx_done_o <= 1'b0;
    end else if (ce_i) begin
      tx_ready_o <= cfg_i.tx_en && txb_ready && !(tx_wr_i && tx_ready_o);
      tx_empty_o <= !txb_valid && !(tx_wr_i && tx_ready_o);
      tx_done_o <= (state_ff == UMSR_TRAIL) && tick && last_bit
                   && !txb_valid;
    end
  end

  // ----------------------------------------------------------------
  // Receive output
  // ----------------------------------------------------------------
  // The output shows the buffer head. After a take it drops for one
  // cycle so the next word is read once the pop has settled; this
  // costs a bubble but never shows one word twice.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_valid_o <= 1'b0;
      rx_word_o <= '0;
    end else if (ce_i) begin
      if (!cfg_i.rx_en) begin
        rx_valid_o <= 1'b0;
      end else if (rx_take) begin
        rx_valid_o <= 1'b0;
      end else if (!rx_valid_o) begin
        rx_valid_o <= rxb_valid;
        rx_word_o <= '{err: ERR_NONE, data: rxb_data};
      end
    end
  end

endmodule

// ---- tb/umsr_spi_slave.sv ----
// Behavioural SPI slave facing the master port
`timescale 1ns/1ps
module umsr_spi_slave (
  input wire logic core_clk_i,
  input wire logic ss_n_i,
  input wire logic cpol_i,
  input wire logic cpha_i,
  input wire logic lsb_i,
  input wire logic sclk_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic [7:0] got_o
);
  // ----------------------------------------
  // Shift engine
  // ----------------------------------------
  logic sclk_ff = 1'b0;
  logic mosi_ff = 1'b0;
  logic rel_ff = 1'b1;
  logic [3:0] cnt_ff = 4'h0;
  logic [7:0] sr_ff = 8'h00;
  logic [7:0] rx_ff = 8'h00;
  logic [7:0] resp_ff = 8'h3C;
  logic lead, samp, shft;

  // Puts a byte in wire order for the chosen bit order
  function automatic logic [7:0] ord(input logic [7:0] x);
    for (int i = 0; i < 8; i++) begin
      ord[i] = lsb_i ? x[7-i] : x[i];
    end
  endfunction

  // Sample edge per the phase setting, shift on the other edge
  assign lead = sclk_i != sclk_ff && sclk_i != cpol_i;
  assign samp = sclk_i != sclk_ff && lead != cpha_i;
  assign shft = sclk_i != sclk_ff && lead == cpha_i && cnt_ff != 4'h0;
  assign miso_o = sr_ff[7];

  // Pre-edge data is sampled, since the edge is seen a cycle late
  always_ff @(posedge core_clk_i) begin
    sclk_ff <= sclk_i;
    mosi_ff <= mosi_i;
    if (ss_n_i) begin
      cnt_ff <= 4'h0;
      rel_ff <= 1'b1;
      sr_ff <= ~sr_ff; // Deselected line flickers
    end else if (rel_ff) begin
      rel_ff <= 1'b0;
      sr_ff <= ord(resp_ff);
    end else if (samp) begin
      rx_ff <= {rx_ff[6:0], mosi_ff};
      cnt_ff <= cnt_ff + 4'h1;
      if (cnt_ff == 4'h7) begin
        cnt_ff <= 4'h0;
        got_o <= ord({rx_ff[6:0], mosi_ff});
        resp_ff <= resp_ff + 8'h29;
        sr_ff <= ord(resp_ff + 8'h29);
      end
    end else if (shft) begin
      sr_ff <= {sr_ff[6:0], 1'b0};
    end
  end
endmodule

// ---- tb/umsr_core_chk.sv ----
// Assertion checker bound to the master SPI port
`timescale 1ns/1ps
module umsr_core_chk (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire umsr_pkg::umsr_cfg_s cfg_i,
  input wire logic tx_wr_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_ready_o,
  input wire logic rx_valid_o,
  input wire logic rx_ready_i,
  input wire umsr_pkg::umsr_rx_s rx_word_o,
  input wire logic tx_empty_o,
  input wire logic tx_done_o,
  input wire logic xfer_clk_o,
  input wire logic mosi_o,
  input wire logic mosi_oe_o,
  input wire logic miso_i,
  input wire logic tx_dir_o
);
  import umsr_pkg::*;
  // ----------------------------------------
  // Clock pin history and properties
  // ----------------------------------------
  logic clk_q_ff;
  logic [15:0] gap_ff;

  // Cycles since the last clock pin change; saturates over idle gaps
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      clk_q_ff <= 1'b0;
      gap_ff <= 16'h0000;
    end else begin
      clk_q_ff <= xfer_clk_o;
      if (clk_q_ff != xfer_clk_o) begin
        gap_ff <= 16'h0000;
      end else if (gap_ff != 16'hFFFF) begin
        gap_ff <= gap_ff + 16'h0001;
      end
    end
  end

  default clocking dc @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // A polarity change while idle also moves the pin, so it is excluded
  sequence s_edge;
    clk_q_ff != xfer_clk_o && cfg_i.cpol == $past(cfg_i.cpol, 2)
      && !$past(rst_i, 2);
  endsequence
  sequence s_trail;
    s_edge ##0 (clk_q_ff != cfg_i.cpol && cfg_i.tx_en);
  endsequence

  property p_tx_off;
    (!cfg_i.tx_en) [*3] |-> xfer_clk_o == cfg_i.cpol && !tx_ready_o;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("busy unenabled");
  property p_err;
    rx_word_o.err == ERR_NONE;
  endproperty
  a_err: assert property (p_err) else $error("error flags set");
  property p_done;
    tx_done_o |-> tx_empty_o && xfer_clk_o == cfg_i.cpol ##1 !tx_done_o;
  endproperty
  a_done: assert property (p_done) else $error("bad done");
  property p_dir;
    cfg_i.rs485 != RS485_OFF && $stable(cfg_i.cpol)
      && xfer_clk_o != cfg_i.cpol |-> tx_dir_o;
  endproperty
  a_dir: assert property (p_dir) else $error("direction low");
  property p_dir_lead;
    $rose(tx_dir_o) |-> xfer_clk_o == cfg_i.cpol;
  endproperty
  a_dir_lead: assert property (p_dir_lead) else $error("direction late");
  property p_oe_int;
    cfg_i.rs485 == RS485_INT && $stable(cfg_i.cpol)
      && xfer_clk_o != cfg_i.cpol |-> mosi_oe_o && tx_dir_o;
  endproperty
  a_oe_int: assert property (p_oe_int) else $error("drive off");
  property p_oe_off;
    cfg_i.rs485 == RS485_OFF && $stable(cfg_i) && !$past(rst_i)
      |-> mosi_oe_o == cfg_i.tx_en;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("bad enable");
  property p_half;
    s_trail |-> gap_ff == cfg_i.baud_div;
  endproperty
  a_half: assert property (p_half) else $error("bad half");
  property p_mosi;
    s_edge ##0 ((xfer_clk_o != cfg_i.cpol) != cfg_i.cpha) |-> $stable(mosi_o);
  endproperty
  a_mosi: assert property (p_mosi) else $error("data moved");
  property p_rx_off;
    (!cfg_i.rx_en) [*2] |-> !rx_valid_o;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("rx kept");
endmodule

bind umsr_core umsr_core_chk u_chk (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i), .cfg_i(cfg_i),
  .tx_wr_i(tx_wr_i), .tx_data_i(tx_data_i), .tx_ready_o(tx_ready_o),
  .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i),
  .rx_word_o(rx_word_o), .tx_empty_o(tx_empty_o), .tx_done_o(tx_done_o),
  .xfer_clk_o(xfer_clk_o), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o),
  .miso_i(miso_i), .tx_dir_o(tx_dir_o)
);

// ---- tb/test_umsr_core.sv ----
// Bench for the master SPI port against a behavioural slave
`timescale 1ns/1ps
module test_umsr_core;
  import umsr_pkg::*;
  // ----------------------------------------
  // Stimulus and checks
  // ----------------------------------------
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic tx_wr_i = 1'b0;
  logic rx_ready_i = 1'b0;
  logic ss_n = 1'b1;
  logic [7:0] tx_data_i = 8'h00;
  logic [7:0] resp = 8'h3C;
  logic [7:0] got;
  umsr_cfg_s cfg_i = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 16'h0001};
  umsr_rx_s rx_word_o;
  logic tx_ready_o, rx_valid_o, tx_empty_o, tx_done_o, tx_dir_o;
  logic xfer_clk_o, mosi_o, mosi_oe_o, miso_i;
  int n_errors = 0;
  int n_compared = 0;

  umsr_core DUT (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(1'b1), .cfg_i(cfg_i),
    .tx_wr_i(tx_wr_i), .tx_data_i(tx_data_i), .tx_ready_o(tx_ready_o),
    .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i),
    .rx_word_o(rx_word_o), .tx_empty_o(tx_empty_o), .tx_done_o(tx_done_o),
    .xfer_clk_o(xfer_clk_o), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o),
    .miso_i(miso_i), .tx_dir_o(tx_dir_o)
  );
  // Select line is ours: the port has none of its own
  umsr_spi_slave u_slave (
    .core_clk_i(core_clk_i), .ss_n_i(ss_n), .cpol_i(cfg_i.cpol),
    .cpha_i(cfg_i.cpha), .lsb_i(cfg_i.lsb_first), .sclk_i(xfer_clk_o),
    .mosi_i(mosi_o), .miso_o(miso_i), .got_o(got)
  );

  // Free-running core clock
  initial begin
    forever #4 core_clk_i = ~core_clk_i;
  end

  task automatic complete_run;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  // Bounded wait: 0 write room, 1 word received, 2 frame done
  task automatic wait_hi(input int sel);
    int k;
    k = 0;
    while (k < 600 && !(sel == 0 ? tx_ready_o === 1'b1 :
        sel == 1 ? rx_valid_o === 1'b1 : tx_done_o === 1'b1)) begin
      tick(1);
      k++;
    end
    if (k == 600) n_errors++;
  endtask

  // One-cycle write strobe; a spare cycle lets the room flag catch up
  task automatic wr(input logic [7:0] b);
    wait_hi(0);
    @(posedge core_clk_i);
    tx_wr_i <= 1'b1;
    tx_data_i <= b;
    @(posedge core_clk_i);
    tx_wr_i <= 1'b0;
    tick(1);
  endtask

  task automatic rd;
    wait_hi(1);
    check("rx data", rx_word_o.data, resp);
    resp = resp + 8'h29;
    @(posedge core_clk_i);
    rx_ready_i <= 1'b1;
    @(posedge core_clk_i);
    rx_ready_i <= 1'b0;
    tick(1);
  endtask

  task automatic xfer(input logic [7:0] b);
    wr(b);
    rd();
    check("slave byte", got, b);
  endtask

  // Reselecting the slave resynchronises its bit count
  task automatic sel(input logic pol, pha, lsb, input logic [1:0] rs);
    @(posedge core_clk_i);
    ss_n <= 1'b1;
    cfg_i.cpol <= pol;
    cfg_i.cpha <= pha;
    cfg_i.lsb_first <= lsb;
    cfg_i.rs485 <= rs;
    repeat (4) @(posedge core_clk_i);
    ss_n <= 1'b0;
    tick(3);
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    for (int m = 0; m < 12; m++) begin
      sel(m[0], m[1], m[2], 2'(m % 3));
      xfer(8'h96 ^ 8'(m * 37));
    end
    // Reader stalls: two words land, the third waits, the queue fills
    for (int i = 1; i < 5; i++) begin
      wr(8'(i * 17));
    end
    tick(100);
    check("room", 8'(tx_ready_o), 8'h00);
    check("empty", 8'(tx_empty_o), 8'h00);
    @(posedge core_clk_i);
    tx_wr_i <= 1'b1;
    tx_data_i <= 8'h55;
    @(posedge core_clk_i);
    tx_wr_i <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd();
    end
    check("last byte", got, 8'h44);
    tick(80);
    check("drained", 8'(tx_empty_o), 8'h01);
    check("no extra", 8'(rx_valid_o), 8'h00);
    // Transmitter dropped mid-frame
    wr(8'hC3);
    tick(9);
    cfg_i.tx_en <= 1'b0;
    cfg_i.rs485 <= RS485_OFF;
    ss_n <= 1'b1;
    tick(6);
    check("abort room", 8'(tx_ready_o), 8'h00);
    check("abort clk", 8'(xfer_clk_o), 8'(cfg_i.cpol));
    cfg_i.tx_en <= 1'b1;
    tick(40);
    check("abort rx", 8'(rx_valid_o), 8'h00);
    sel(cfg_i.cpol, cfg_i.cpha, cfg_i.lsb_first, RS485_OFF);
    // Send only, receiver off
    cfg_i.rx_en <= 1'b0;
    wr(8'h5A);
    wait_hi(2);
    tick(4);
    check("tx only", got, 8'h5A);
    check("rx off", 8'(rx_valid_o), 8'h00);
    resp = resp + 8'h29;
    cfg_i.rx_en <= 1'b1;
    tick(2);
    xfer(8'hE7);
    complete_run();
  end

  // Whole run needs well under this many cycles
  initial begin
    repeat (30000) @(posedge core_clk_i);
    n_errors++;
    complete_run();
  end
endmodule
